// ==== rtl/tpt_translate.sv ====
// Two-level page translation unit with a 64-entry look-aside buffer.
// Assumes a core request port, a word-wide table-read port, AHB-Lite registers.
// Operation
// - Every 32-bit virtual address is mapped when translation is on for the mode.
// - Pages are fixed 4096-byte units, one mapping entry per page.
// - A 64-entry look-aside buffer caches recent translations.
// - Needed references with a fault raise the abort trap.
// - Base register finds level-one table, its entry finds level-two table.
// - Level-one table is 1024 words of 32 bits.
// - Level-one frame field gives bits 12..31 of level-two table base.
// - Level-two table is 1024 words; its frame gives address bits 12..31.
// - Byte offset passes through unchanged.
// - Supervisor references use space zero and base register zero.
// - User references with dual space set use space one and base one.
// - Without dual space everything uses space zero; mode only sets privilege.
// - Dual-space moves arrive flagged as user and are treated as user.
// - Privilege override gives user accesses supervisor privilege.
// - Cause codes 00/01/10/11; protection outranks invalid.
// - Separate user and supervisor enables; disabled means identity map.
// - An entry with valid clear causes an abort.
// - Entry address is table base plus ten-bit index times four.
module tpt_translate
  import tpt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic core_req_valid,
  output logic core_req_ready,
  input wire logic [31:0] core_vaddr,
  input wire logic core_user,
  input wire logic core_write,
  input wire logic core_rmw,
  input wire logic core_needed,
  output logic core_resp_valid,
  output logic [31:0] core_paddr,
  output logic core_resp_fault,
  output logic abort_trap,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  function automatic logic [1:0] pte_pl(input logic [31:0] pte);
    pte_pl = pte[PTE_PL_LSB +: 2];
  endfunction

  function automatic logic [1:0] min_pl(input logic [1:0] a, input logic [1:0] b);
    min_pl = (a < b) ? a : b;
  endfunction

  tpt_state_t state_q, state_d;
  logic [31:0] base0_q, base1_q, faddr_q;
  logic [3:0] ctrl_q, stat_q;
  logic [31:0] va_q;
  logic user_q, wr_q, rmw_q, need_q;
  logic [1:0] eff_pl_q;
  logic a_wr_q;
  logic [7:0] a_addr_q;
  logic [TLB_N-1:0] tlb_vld_q;
  logic [TAG_W-1:0] tlb_tag_q [TLB_N];
  logic [19:0] tlb_pfn_q [TLB_N];
  logic [1:0] tlb_pl_q [TLB_N];

  // Bus decode
  wire bus_go = hsel && htrans[1] && hready;
  wire [7:0] rd_ofs = haddr[7:0];
  wire mapped = haddr[31:8] == 24'h0;
  wire [31:0] rd_word =
    !mapped ? WORD_RST :
    (rd_ofs == OFS_BASE0) ? base0_q :
    (rd_ofs == OFS_BASE1) ? base1_q :
    (rd_ofs == OFS_CTRL) ? {28'h0, ctrl_q} :
    (rd_ofs == OFS_STAT) ? {28'h0, stat_q} :
    (rd_ofs == OFS_FADDR) ? faddr_q : WORD_RST;
  wire wr_base0 = a_wr_q && a_addr_q == OFS_BASE0;
  wire wr_base1 = a_wr_q && a_addr_q == OFS_BASE1;
  wire wr_ctrl = a_wr_q && a_addr_q == OFS_CTRL;
  wire wr_stat = a_wr_q && a_addr_q == OFS_STAT;
  wire wr_inval = a_wr_q && a_addr_q == OFS_INVAL;
  wire [TLB_IW-1:0] inval_idx = hwdata[OFF_W +: TLB_IW];

  // dual-space moves arrive with core_user high
  // user with dual space uses space one
  // without dual space always space zero
  wire as_one = user_q && ctrl_q[CTL_DS];
  wire [31:0] tbl_base = as_one ? base1_q : base0_q;
  // override lifts user accesses to supervisor level
  wire [1:0] acc_lvl = {user_q && !ctrl_q[CTL_AO], wr_q || rmw_q};
  wire xl_en = user_q ? ctrl_q[CTL_TU] : ctrl_q[CTL_TS];

  // direct-mapped buffer lookup, tagged with address space
  wire [TLB_IW-1:0] tlb_idx = va_q[OFF_W +: TLB_IW];
  wire [TAG_W-1:0] tlb_tag = {as_one, va_q[31:OFF_W+TLB_IW]};
  wire hit = tlb_vld_q[tlb_idx] && tlb_tag_q[tlb_idx] == tlb_tag;
  wire hit_prot = tlb_pl_q[tlb_idx] < acc_lvl;

  // level-one index picks one of 1024 words
  wire [31:0] l1_addr = {tbl_base[31:OFF_W], va_q[31:IDX1_LSB], 2'b00};
  // level-one frame gives level-two base, low bits zero
  // level-two index picks one of 1024 words
  wire [31:0] l2_addr = {mem_rdata[31:OFF_W], va_q[IDX1_LSB-1:OFF_W], 2'b00};

  // Request is taken only while ready is shown
  wire take = state_q == TPT_IDLE && core_req_valid && core_req_ready;
  wire look_dis = state_q == TPT_LOOK && !xl_en;
  wire look_hit = state_q == TPT_LOOK && xl_en && hit;
  wire look_miss = state_q == TPT_LOOK && xl_en && !hit;
  wire f1_done = state_q == TPT_FETCH1 && mem_ack;
  wire f2_done = state_q == TPT_FETCH2 && mem_ack;
  wire pte_prot = pte_pl(mem_rdata) < acc_lvl;
  wire pte_inval = !mem_rdata[PTE_V];
  wire f1_bad = f1_done && (pte_prot || pte_inval);
  wire fin = look_dis || look_hit || f1_bad || f2_done;

  wire [1:0] fin_cause =
    look_hit ? (hit_prot ? CAUSE_PROT : CAUSE_NONE) :
    f1_done ? (pte_prot ? CAUSE_PROT : CAUSE_L1) :
    f2_done ? (pte_prot ? CAUSE_PROT : pte_inval ? CAUSE_L2 : CAUSE_NONE) :
    CAUSE_NONE;
  wire fin_fault = fin_cause != CAUSE_NONE;
  wire fill = f2_done && !fin_fault;
  // frame replaces bits above the 4096-byte offset
  wire [31:0] fin_pa =
    look_dis ? va_q :
    look_hit ? {tlb_pfn_q[tlb_idx], va_q[OFF_W-1:0]} :
    {mem_rdata[31:OFF_W], va_q[OFF_W-1:0]};
  // only needed references record a fault and trap
  wire log_fault = fin && fin_fault && need_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TPT_IDLE: if (take) state_d = TPT_LOOK;
      TPT_LOOK: if (look_miss) state_d = TPT_FETCH1;
      else state_d = TPT_IDLE;
      TPT_FETCH1: if (f1_bad) state_d = TPT_IDLE;
      else if (f1_done) state_d = TPT_FETCH2;
      TPT_FETCH2: if (f2_done) state_d = TPT_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= TPT_IDLE;
      core_req_ready <= 1'b0;
    end else begin
      state_q <= state_d;
      core_req_ready <= state_d == TPT_IDLE && !take;
    end
  end

  // Request capture; accepted only while ready is shown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      va_q <= WORD_RST;
      {user_q, wr_q, rmw_q, need_q} <= 4'h0;
    end else if (take) begin
      va_q <= core_vaddr;
      {user_q, wr_q, rmw_q, need_q} <= {core_user, core_write, core_rmw, core_needed};
    end
  end

  // one answer per request, translated or identity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_resp_valid <= 1'b0;
      core_paddr <= WORD_RST;
      core_resp_fault <= 1'b0;
      abort_trap <= 1'b0;
    end else begin
      core_resp_valid <= fin;
      core_resp_fault <= fin && fin_fault;
      abort_trap <= log_fault;
      if (fin) core_paddr <= fin_fault ? WORD_RST : fin_pa;
    end
  end

  // table reads only on a miss, level one first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= 1'b0;
      mem_addr <= WORD_RST;
      eff_pl_q <= 2'h0;
    end else if (look_miss) begin
      mem_req <= 1'b1;
      mem_addr <= l1_addr;
    end else if (f1_done && !f1_bad) begin
      mem_addr <= l2_addr;
      eff_pl_q <= pte_pl(mem_rdata);
    end else if (f1_bad || f2_done) begin
      mem_req <= 1'b0;
    end
  end

  // Purge wins over a fill in the same cycle; a walk still running at a base change fills after it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tlb_vld_q <= '0;
    end else if (wr_base0 || wr_base1) begin
      tlb_vld_q <= '0;
    end else if (wr_inval) begin
      tlb_vld_q[inval_idx] <= 1'b0;
    end else if (fill) begin
      tlb_vld_q[tlb_idx] <= 1'b1;
    end
  end

  // fill keeps the most restrictive level seen on the walk
  always_ff @(posedge hclk) begin
    if (fill) begin
      tlb_tag_q[tlb_idx] <= tlb_tag;
      tlb_pfn_q[tlb_idx] <= mem_rdata[31:OFF_W];
      tlb_pl_q[tlb_idx] <= min_pl(eff_pl_q, pte_pl(mem_rdata));
    end
  end

  // Bus slave: zero wait states, read data prepared in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr_q <= 1'b0;
      a_addr_q <= 8'h0;
      hrdata <= WORD_RST;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      a_wr_q <= bus_go && hwrite && mapped;
      a_addr_q <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (bus_go && !hwrite) hrdata <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base0_q <= WORD_RST;
      base1_q <= WORD_RST;
      ctrl_q <= CTL_RST;
    end else begin
      if (wr_base0) base0_q <= hwdata;
      if (wr_base1) base1_q <= hwdata;
      if (wr_ctrl) ctrl_q <= hwdata[3:0];
    end
  end

  // a fault capture wins over a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= STA_RST;
      faddr_q <= WORD_RST;
    end else if (log_fault) begin
      stat_q <= {user_q, wr_q || rmw_q, fin_cause};
      faddr_q <= va_q;
    end else if (wr_stat) begin
      stat_q <= hwdata[3:0];
    end
  end

  // Checks
  // identity map
  AST_IDENTITY: assert property (@(posedge hclk) disable iff (!hresetn)
    look_dis |=> core_resp_valid && !core_resp_fault && core_paddr == $past(va_q))
    else $error("identity map broken");

  AST_OFFSET: assert property (@(posedge hclk) disable iff (!hresetn)
    (core_resp_valid && !core_resp_fault) |-> core_paddr[11:0] == va_q[11:0])
    else $error("offset changed");

  AST_BASE_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
    look_miss |=> mem_req &&
      mem_addr[31:12] == ((user_q && ctrl_q[CTL_DS]) ? base1_q[31:12] : base0_q[31:12]))
    else $error("wrong table base");

  AST_L1_INDEX: assert property (@(posedge hclk) disable iff (!hresetn)
    look_miss |=> mem_addr[11:0] == {va_q[31:22], 2'b00})
    else $error("level-one index wrong");

  AST_L2_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
    (f1_done && !f1_bad) |=> state_q == TPT_FETCH2 &&
      mem_addr == {$past(mem_rdata[31:12]), va_q[21:12], 2'b00})
    else $error("level-two address wrong");

  AST_FRAME: assert property (@(posedge hclk) disable iff (!hresetn)
    (f2_done && !fin_fault) |=> core_resp_valid && core_paddr[31:12] == $past(mem_rdata[31:12]))
    else $error("frame not used");

  AST_PROT_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
    (f1_done && pte_prot && need_q) |=> stat_q[1:0] == 2'b11 && abort_trap)
    else $error("protection cause wrong");

  AST_L1_INVALID: assert property (@(posedge hclk) disable iff (!hresetn)
    (f1_done && !pte_prot && pte_inval) |=> core_resp_fault && !mem_req && core_paddr == WORD_RST)
    else $error("invalid entry not faulted");

  // hit answers with no table read
  AST_HIT_NOREAD: assert property (@(posedge hclk) disable iff (!hresetn)
    look_hit |=> core_resp_valid && !mem_req)
    else $error("hit issued a table read");

  AST_TRAP_NEED: assert property (@(posedge hclk) disable iff (!hresetn)
    abort_trap |-> core_resp_fault && $past(need_q))
    else $error("trap on unneeded reference");

  AST_L2_INVALID: assert property (@(posedge hclk) disable iff (!hresetn)
    (f2_done && !pte_prot && pte_inval) |=> core_resp_fault && core_paddr == WORD_RST)
    else $error("invalid level-two entry not faulted");

  AST_L2_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
    (f2_done && !pte_prot && pte_inval && need_q) |=> stat_q == {user_q, wr_q || rmw_q, CAUSE_L2})
    else $error("level-two cause wrong");

  AST_BUSY_REFUSE: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q != TPT_IDLE |-> !core_req_ready)
    else $error("ready shown while busy");

endmodule // tpt_translate

// ==== rtl/tpt_pkg.sv ====
// Constants for the two-level page translation block.
// Assumes a single 200 MHz clock and a 32-bit AHB-Lite register bus.
package tpt_pkg;
  localparam int unsigned VA_W = 32;
  localparam int unsigned PAGE_BYTES = 4096;
  localparam int unsigned OFF_W = $clog2(PAGE_BYTES);
  localparam int unsigned TBL_ENTRIES = 1024;
  localparam int unsigned IDX_W = $clog2(TBL_ENTRIES);
  localparam int unsigned TLB_N = 64;
  localparam int unsigned TLB_IW = $clog2(TLB_N);
  localparam int unsigned TAG_W = 2 * IDX_W - TLB_IW + 1;
  localparam int unsigned IDX1_LSB = OFF_W + IDX_W;
  // Register byte offsets
  localparam logic [7:0] OFS_BASE0 = 8'h00;
  localparam logic [7:0] OFS_BASE1 = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_FADDR = 8'h10;
  localparam logic [7:0] OFS_INVAL = 8'h14;
  // translation_control fields
  localparam int unsigned CTL_TU = 0;
  localparam int unsigned CTL_TS = 1;
  localparam int unsigned CTL_DS = 2;
  localparam int unsigned CTL_AO = 3;
  localparam logic [3:0] CTL_RST = 4'h0;
  // translation_fault_status fields
  localparam int unsigned STA_DIR = 2;
  localparam int unsigned STA_USR = 3;
  localparam logic [3:0] STA_RST = 4'h0;
  // Page table entry fields
  localparam int unsigned PTE_V = 0;
  localparam int unsigned PTE_PL_LSB = 1;
  // Fault causes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_L1 = 2'h1;
  localparam logic [1:0] CAUSE_L2 = 2'h2;
  localparam logic [1:0] CAUSE_PROT = 2'h3;
  localparam logic [31:0] WORD_RST = 32'h0;
  typedef enum logic [1:0] {
    TPT_IDLE = 2'b00,
    TPT_LOOK = 2'b01,
    TPT_FETCH1 = 2'b11,
    TPT_FETCH2 = 2'b10
  } tpt_state_t;
endpackage : tpt_pkg

// ==== testbench/tpt_mem_model.sv ====
// Page table memory model behind the table-read port.
// Assumes one outstanding word read, each acked once; mem_req stays high over both table reads of a walk.
module tpt_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] tbl [logic [31:0]];
  int rd_cnt = 0;
  int wait_n;
  function automatic logic [31:0] rd(input logic [31:0] a);
    return tbl.exists(a) ? tbl[a] : 32'h0;
  endfunction
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_n <= 0;
    end else if (mem_req && !mem_ack && wait_n == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= rd(mem_addr);
      rd_cnt <= rd_cnt + 1;
      wait_n <= slow ? $urandom_range(5) : 0;
    end else begin
      mem_ack <= 1'b0;
      // Stale data is inverted every cycle, so it does not stay steady
      mem_rdata <= ~mem_rdata;
      if (mem_req && wait_n > 0) wait_n <= wait_n - 1;
    end
  end
endmodule // tpt_mem_model

// ==== testbench/tb.sv ====
// Self-checking bench for the page translation unit.
// Assumes the unit answers each core request once; expectations queue in order.
module tb
  import tpt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] pa; logic [1:0] ca; logic tr; int rd;} tpt_exp_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
  logic core_req_valid = 0, core_user = 0, core_write = 0, core_rmw = 0, core_needed = 0;
  logic [31:0] haddr = 0, hwdata = 0, core_vaddr = 0, va, base0, base1, p1, rdv;
  logic [1:0] htrans = 0;
  logic u, w, m, n;
  logic [3:0] ctrl = 0, st = 0;
  wire logic hreadyout, hresp, core_req_ready, core_resp_valid, core_resp_fault, abort_trap, mem_req, mem_ack;
  wire logic [31:0] hrdata, core_paddr, mem_addr, mem_rdata;
  int fails = 0, num_checks = 0, snap;
  logic [31:0] reg_ofs [5] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h18};
  tpt_exp_t q[$], me;
  tpt_translate DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .core_req_valid, .core_req_ready, .core_vaddr,
    .core_user, .core_write, .core_rmw, .core_needed, .core_resp_valid, .core_paddr, .core_resp_fault,
    .abort_trap, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
  tpt_mem_model mem (.hclk, .hresetn, .slow, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
  initial forever #2.5 hclk = ~hclk;
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // Expected answer worked out from the table contents
  function automatic tpt_exp_t calc();
    tpt_exp_t e;
    logic [31:0] b, p2;
    logic [1:0] lvl;
    e = '{pa: va, ca: CAUSE_NONE, tr: 1'b0, rd: 0};
    if (!(u ? ctrl[CTL_TU] : ctrl[CTL_TS])) return e;
    b = (u && ctrl[CTL_DS]) ? base1 : base0;
    lvl = {u & !ctrl[CTL_AO], w | m};
    p1 = mem.rd({b[31:12], va[31:22], 2'b00});
    e.rd = 1;
    if (p1[2:1] < lvl) e.ca = CAUSE_PROT;
    else if (!p1[PTE_V]) e.ca = CAUSE_L1;
    else begin
      p2 = mem.rd({p1[31:12], va[21:12], 2'b00});
      e.rd = 2;
      if (p2[2:1] < lvl) e.ca = CAUSE_PROT;
      else if (!p2[PTE_V]) e.ca = CAUSE_L2;
      else e.pa = {p2[31:12], va[11:0]};
    end
    if (e.ca != CAUSE_NONE) e.pa = 32'h0;
    e.tr = (e.ca != CAUSE_NONE) && n;
    return e;
  endfunction
  task req(input bit hit);
    tpt_exp_t e;
    e = calc();
    if (hit && e.ca == CAUSE_NONE) e.rd = 0;
    @(posedge hclk);
    core_req_valid <= 1'b1;
    core_vaddr <= va;
    core_user <= u;
    core_write <= w;
    core_rmw <= m;
    core_needed <= n;
    @(posedge hclk);
    while (core_req_ready !== 1'b1) @(posedge hclk);
    snap = mem.rd_cnt;
    q.push_back(e);
    core_req_valid <= 1'b0;
    for (int k = 0; k < 300 && q.size() > 0; k++) @(posedge hclk);
    check(32'(q.size()), 32'h0);
    q.delete();
    if (e.tr) st = {u, w | m, e.ca};
    bus(1'b0, 32'(OFS_STAT), 32'h0, rdv);
    check(rdv, {28'h0, st});
    if (e.tr) begin
      bus(1'b0, 32'(OFS_FADDR), 32'h0, rdv);
      check(rdv, va);
    end
  endtask
  always @(negedge hclk) begin
    if (core_resp_valid === 1'b1) begin
      if (q.size() == 0) begin
        fails++;
        $display("Error at %0t: answer without request", $time);
      end else begin
        me = q.pop_front();
        check(core_paddr, me.pa);
        check({30'h0, core_resp_fault, abort_trap}, {30'h0, me.ca != CAUSE_NONE, me.tr});
        check(32'(mem.rd_cnt - snap), 32'(me.rd));
      end
    end
  end
  initial begin
    #200us;
    fails++;
    $display("Error at %0t: timeout", $time);
    end_sim();
  end
  initial begin
    void'($urandom(32'h5a21efdf));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    foreach (reg_ofs[i]) begin
      bus(1'b0, reg_ofs[i], 32'h0, rdv);
      check(rdv, 32'h0);
    end
    bus(1'b1, 32'h18, 32'hffffffff, rdv);
    bus(1'b0, 32'h18, 32'h0, rdv);
    check(rdv, 32'h0);
    bus(1'b1, 32'(OFS_CTRL), 32'hffffffff, rdv);
    bus(1'b0, 32'(OFS_CTRL), 32'h0, rdv);
    check(rdv, 32'hf);
    st = 4'h5;
    bus(1'b1, 32'(OFS_STAT), {28'h0, st}, rdv);
    bus(1'b0, 32'(OFS_STAT), 32'h0, rdv);
    check(rdv, {28'h0, st});
    check({31'h0, hresp}, 32'h0);
    $display("Register test done");
    for (int i = 0; i < 40; i++) begin
      ctrl = 4'($urandom);
      {u, w, m, n} = 4'($urandom);
      va = $urandom;
      slow <= 1'($urandom);
      base0 = {4'h1, 16'($urandom), 12'h0};
      base1 = {4'h2, 16'($urandom), 12'h0};
      p1 = (u && ctrl[CTL_DS]) ? base1 : base0;
      p1 = {p1[31:12], va[31:22], 2'b00};
      mem.tbl[p1] = {4'h8, 16'($urandom), 9'h0, 3'($urandom)};
      p1 = mem.tbl[p1];
      mem.tbl[{p1[31:12], va[21:12], 2'b00}] = $urandom;
      bus(1'b1, 32'(OFS_BASE0), base0, rdv);
      bus(1'b1, 32'(OFS_BASE1), base1, rdv);
      bus(1'b1, 32'(OFS_CTRL), {28'h0, ctrl}, rdv);
      bus(1'b0, 32'(OFS_BASE1), 32'h0, rdv);
      check(rdv, base1);
      req(1'b0);
      req(1'b1);
      bus(1'b1, 32'(OFS_INVAL), va, rdv);
      req(1'b0);
    end
    $display("Translation test done");
    end_sim();
  end
endmodule // tb
